/* logic/l2_policy_pkg.sv */
// shared constants for the level-two attribute policy block
// assumes a 32-bit core address and a 64-bit master data bus
package l2_policy_pkg;
    // register map of the plain register port
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_WA_OVR_BIT = 0;
    localparam int CTRL_SH_OVR_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // line store shape: one word per line, direct mapped
    localparam int IDX_W = 4;
    localparam int NLINES = 16;
    localparam int TAG_W = 26;
    localparam int TAG_LSB = 6;
    localparam int IDX_LSB = 2;
    // write buffer
    localparam int SLOTS = 2;
    localparam int USE_W = 4;
    localparam logic [USE_W-1:0] USE_MAX = 4'hF;
endpackage

/* logic/attr_decode.sv */
// turns protection and sideband attributes into cache policy bits
// assumes attributes are stable while the request is valid
`timescale 1ns/1ns
`default_nettype none
module attr_decode
    import l2_policy_pkg::*;
(
    input wire logic [2:0] slave_port_protection_attrs_i, // allocate, cacheable, bufferable
    input wire logic shared_attribute_sideband_i,
    input wire logic shared_ovr_i,
    input wire logic wa_ovr_i,
    output logic lookup_o,
    output logic buffered_o,
    output logic fill_rd_o,
    output logic alloc_o,
    output logic wb_o
);
    wire alloc_bit = slave_port_protection_attrs_i[2];
    wire cache_bit = slave_port_protection_attrs_i[1];
    wire buf_bit = slave_port_protection_attrs_i[0];
    // override makes shared look nonshared inside the block
    wire shared_eff = shared_attribute_sideband_i & ~shared_ovr_i; // [RQ19]
    // cacheable types are write-through, write-back alloc or write-back no-alloc
    wire cached_type = cache_bit & (alloc_bit | buf_bit); // [RQ13] [RQ14]
    wire outer_writeback_alloc = cached_type & ~alloc_bit & buf_bit; // [RQ15]
    wire outer_writethrough_noalloc = cached_type & alloc_bit & ~buf_bit; // [RQ16]
    wire outer_writeback_noalloc = cached_type & alloc_bit & buf_bit; // [RQ17]

    // shared cacheable: buffered, never looked up or filled
    assign buffered_o = cached_type; // [RQ18]
    assign lookup_o = cached_type & ~shared_eff; // [RQ20]
    assign fill_rd_o = lookup_o;
    assign wb_o = outer_writeback_alloc | outer_writeback_noalloc;
    assign alloc_o = lookup_o & (outer_writeback_alloc | wa_ovr_i); // [RQ5]
    wire unused_wt = outer_writethrough_noalloc;
endmodule
`default_nettype wire

/* logic/line_store.sv */
// direct mapped line array: tag, data, valid and dirty per line
// assumes read index is presented one cycle before data is needed
`timescale 1ns/1ns
`default_nettype none
module line_store
    import l2_policy_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic rd_valid_o,
    output logic rd_dirty_o,
    output logic [TAG_W-1:0] rd_tag_o,
    output logic [31:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [TAG_W-1:0] wr_tag_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_dirty_i
);
    logic [TAG_W-1:0] tag_mem [NLINES];
    logic [31:0] data_mem [NLINES];
    logic [NLINES-1:0] valid_ff;
    logic [NLINES-1:0] dirty_ff;

    // arrays carry no reset; only the valid and dirty flag bits get one
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            tag_mem[wr_idx_i] <= wr_tag_i;
            data_mem[wr_idx_i] <= wr_data_i;
        end
        rd_tag_o <= tag_mem[rd_idx_i];
        rd_data_o <= data_mem[rd_idx_i];
    end

    // flag bits, read out registered like the data
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            valid_ff <= '0;
            dirty_ff <= '0;
            rd_valid_o <= 1'b0;
            rd_dirty_o <= 1'b0;
        end else begin
            if (wr_en_i) begin
                valid_ff[wr_idx_i] <= 1'b1;
                dirty_ff[wr_idx_i] <= wr_dirty_i;
            end
            rd_valid_o <= valid_ff[rd_idx_i];
            rd_dirty_o <= dirty_ff[rd_idx_i];
        end
    end
endmodule
`default_nettype wire

/* logic/l2_cache_attribute_policy.sv */
// level-two transaction policy: core request port, write buffer, master port
// assumes all request and memory inputs come from logic on ref_clk_i
// How it works
// (RQ1) write-through hit: buffer, update array on drain, also write to memory
// (RQ2) write-back hit: buffer, update array on drain, mark dirty, no memory write
// (RQ3) cacheable write miss without allocation: buffer, forward to memory on drain
// (RQ4) cacheable read hit returns array data; miss linefills then answers core
// (RQ5) write allocate override allocates a line for every cacheable write miss
// (RQ6) drain the write buffer when both slots hold data
// (RQ7) without hazards, drain the least used slot first
// (RQ8) a slot causing a hazard drains ahead of normal order
// (RQ9) core never issues unaligned bursts
// (RQ10) core never ends a noncacheable fixed burst early
// (RQ11) memory write data sits on lanes 31:0, lanes 63:32 stay zero
// (RQ12) memory duplicates read data on both halves
// (RQ13) not cacheable, not allocate: strongly ordered or device, no fills
// (RQ14) allocate 0, cacheable 1, bufferable 0: uncached, unbuffered, no fills
// (RQ15) nonshared write-back allocate: buffer misses, fill on reads and writes
// (RQ16) nonshared write-through: buffer writes, fill on reads only
// (RQ17) nonshared write-back no-allocate: buffer misses, fill on reads only
// (RQ18) shared cacheable access: writes buffered, no linefills
// (RQ19) shared override treats shared accesses as nonshared
// (RQ20) noncacheable accesses skip lookup and go straight to memory
`timescale 1ns/1ns
`default_nettype none
module l2_cache_attribute_policy
    import l2_policy_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // core request port
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic [2:0] slave_port_protection_attrs_i,
    input wire logic shared_attribute_sideband_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [31:0] rsp_rdata_o,
    // master port toward memory
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [31:0] mem_addr_o,
    output logic [63:0] mem_wdata_o,
    input wire logic mem_ready_i,
    input wire logic mem_rvalid_i,
    input wire logic [63:0] mem_rdata_i
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOOK,
        ST_DLOOK,
        ST_EVICT,
        ST_ALLOC,
        ST_MREQ,
        ST_MWAIT
    } state_e;
    state_e st_ff, nxt_st;

    logic [1:0] ctrl_ff;
    logic [31:0] reg_rdata_ff;
    logic rsp_valid_ff;
    logic [31:0] rsp_data_ff;
    // pending operation
    logic [31:0] op_addr_ff, op_data_ff;
    logic op_write_ff, op_lookup_ff, op_fill_ff, op_alloc_ff, op_wb_ff;
    logic [31:0] vict_addr_ff, vict_data_ff;
    // write buffer slots
    logic [SLOTS-1:0] slot_vld_ff;
    logic [31:0] slot_addr_ff [SLOTS];
    logic [31:0] slot_data_ff [SLOTS];
    logic [USE_W-1:0] slot_use_ff [SLOTS];
    logic [SLOTS-1:0] slot_lookup_ff, slot_alloc_ff, slot_wb_ff;
    logic drain_on_ff;

    // attribute decode of the incoming request
    logic dec_lookup, dec_buffered, dec_fill, dec_alloc, dec_wb;
    attr_decode u_dec (
        .slave_port_protection_attrs_i(slave_port_protection_attrs_i),
        .shared_attribute_sideband_i(shared_attribute_sideband_i),
        .shared_ovr_i(ctrl_ff[CTRL_SH_OVR_BIT]),
        .wa_ovr_i(ctrl_ff[CTRL_WA_OVR_BIT]),
        .lookup_o(dec_lookup),
        .buffered_o(dec_buffered),
        .fill_rd_o(dec_fill),
        .alloc_o(dec_alloc),
        .wb_o(dec_wb)
    );

    // slot matching and drain choice
    logic [SLOTS-1:0] slot_hit;
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_match
            assign slot_hit[gi] = slot_vld_ff[gi] && (slot_addr_ff[gi][31:2] == req_addr_i[31:2]);
        end
    endgenerate
    wire both_full = &slot_vld_ff; // [RQ6]
    wire buf_write = req_valid_i & req_write_i & dec_buffered;
    // reads of buffered data and unbuffered traffic must see older writes first
    wire read_hazard = req_valid_i & ~req_write_i & (|slot_hit);
    wire order_hazard = req_valid_i & ~buf_write & (|slot_vld_ff);
    wire lru_sel = !slot_vld_ff[0] ? 1'b1 : !slot_vld_ff[1] ? 1'b0 : (slot_use_ff[1] < slot_use_ff[0]); // [RQ7]
    wire drain_sel = read_hazard ? slot_hit[1] : lru_sel; // [RQ8]
    wire drain_go = both_full | drain_on_ff | read_hazard | order_hazard; // [RQ6] [RQ8]
    wire merge = |slot_hit;
    wire ins_sel = merge ? slot_hit[1] : slot_vld_ff[0];
    wire idle = (st_ff == ST_IDLE);
    wire buf_take = idle & ~drain_go & buf_write;
    wire op_take = idle & ~drain_go & req_valid_i & ~buf_write;

    // a full-buffer drain empties both slots
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            drain_on_ff <= 1'b0;
        end else if (idle && drain_go) begin
            drain_on_ff <= both_full; // [RQ6]
        end
    end

    // line store with a registered read
    logic ent_valid, ent_dirty;
    logic [TAG_W-1:0] ent_tag;
    logic [31:0] ent_data;
    logic arr_wr;
    logic [31:0] arr_wdata;
    logic arr_dirty;
    wire [31:0] rd_addr = !idle ? op_addr_ff : drain_go ? slot_addr_ff[drain_sel] : req_addr_i;
    line_store u_lines (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .rd_idx_i(rd_addr[IDX_LSB +: IDX_W]),
        .rd_valid_o(ent_valid),
        .rd_dirty_o(ent_dirty),
        .rd_tag_o(ent_tag),
        .rd_data_o(ent_data),
        .wr_en_i(arr_wr),
        .wr_idx_i(op_addr_ff[IDX_LSB +: IDX_W]),
        .wr_tag_i(op_addr_ff[TAG_LSB +: TAG_W]),
        .wr_data_i(arr_wdata),
        .wr_dirty_i(arr_dirty)
    );
    wire ent_hit = ent_valid && (ent_tag == op_addr_ff[TAG_LSB +: TAG_W]);
    wire vict_dirty = ent_valid & ent_dirty & ~ent_hit;

    // array writes: drained store data or returned linefill data
    wire fill_back = (st_ff == ST_MWAIT) & mem_rvalid_i & op_fill_ff;
    assign arr_wr = (st_ff == ST_ALLOC) | fill_back; // [RQ4]
    assign arr_wdata = fill_back ? mem_rdata_i[31:0] : op_data_ff;
    assign arr_dirty = ~fill_back & op_wb_ff; // [RQ2]

    // master port: victim during eviction, pending op otherwise
    wire evicting = (st_ff == ST_EVICT);
    assign mem_valid_o = evicting | (st_ff == ST_MREQ);
    assign mem_write_o = evicting | op_write_ff;
    assign mem_addr_o = evicting ? vict_addr_ff : op_addr_ff;
    assign mem_wdata_o = {32'h0000_0000, evicting ? vict_data_ff : op_data_ff}; // [RQ11]
    assign req_ready_o = buf_take | op_take;
    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_rdata_o = rsp_data_ff;
    assign reg_rdata_o = reg_rdata_ff;

    // sequencing of lookup, drain, eviction and memory access
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_IDLE: begin
                if (drain_go) begin
                    nxt_st = ST_DLOOK;
                end else if (op_take) begin
                    nxt_st = (!req_write_i && dec_lookup) ? ST_LOOK : ST_MREQ; // [RQ20]
                end
            end
            ST_LOOK: begin
                if (ent_hit) begin
                    nxt_st = ST_IDLE; // [RQ4]
                end else if (op_fill_ff && vict_dirty) begin
                    nxt_st = ST_EVICT;
                end else begin
                    nxt_st = ST_MREQ;
                end
            end
            ST_DLOOK: begin
                if (!op_lookup_ff) begin
                    nxt_st = ST_MREQ; // [RQ18]
                end else if (ent_hit) begin
                    nxt_st = ST_ALLOC; // [RQ1] [RQ2]
                end else if (op_alloc_ff) begin
                    nxt_st = vict_dirty ? ST_EVICT : ST_ALLOC; // [RQ5] [RQ15]
                end else begin
                    nxt_st = ST_MREQ; // [RQ3]
                end
            end
            ST_EVICT: begin
                if (mem_ready_i) begin
                    nxt_st = op_write_ff ? ST_ALLOC : ST_MREQ;
                end
            end
            ST_ALLOC: begin
                nxt_st = op_wb_ff ? ST_IDLE : ST_MREQ; // [RQ1] [RQ2]
            end
            ST_MREQ: begin
                if (mem_ready_i) begin
                    nxt_st = op_write_ff ? ST_IDLE : ST_MWAIT;
                end
            end
            ST_MWAIT: begin
                if (mem_rvalid_i) begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    // state, core answer and register port
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_ff <= ST_IDLE;
            ctrl_ff <= CTRL_RESET;
            reg_rdata_ff <= 32'h0000_0000;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
            if (reg_wr_i && reg_addr_i == CTRL_OFS) begin
                ctrl_ff <= reg_wdata_i[1:0];
            end
            reg_rdata_ff <= !reg_rd_i ? 32'h0000_0000 :
                reg_addr_i == CTRL_OFS ? {30'h0, ctrl_ff} :
                reg_addr_i == STAT_OFS ? {29'h0, ~idle | drain_on_ff, slot_vld_ff} : 32'h0000_0000;
            rsp_valid_ff <= ((st_ff == ST_LOOK) && ent_hit) || ((st_ff == ST_MWAIT) && mem_rvalid_i);
            // lower half is used; memory duplicates data on both halves
            rsp_data_ff <= (st_ff == ST_LOOK) ? ent_data : mem_rdata_i[31:0]; // [RQ12]
        end
    end

    // capture of the operation in flight
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            op_addr_ff <= 32'h0000_0000;
            op_data_ff <= 32'h0000_0000;
            {op_write_ff, op_lookup_ff, op_fill_ff, op_alloc_ff, op_wb_ff} <= 5'h00;
            vict_addr_ff <= 32'h0000_0000;
            vict_data_ff <= 32'h0000_0000;
        end else begin
            if (idle && drain_go) begin
                op_addr_ff <= slot_addr_ff[drain_sel];
                op_data_ff <= slot_data_ff[drain_sel];
                {op_write_ff, op_fill_ff} <= 2'h2;
                op_lookup_ff <= slot_lookup_ff[drain_sel];
                op_alloc_ff <= slot_alloc_ff[drain_sel];
                op_wb_ff <= slot_wb_ff[drain_sel];
            end else if (op_take) begin
                op_addr_ff <= req_addr_i;
                op_data_ff <= req_wdata_i;
                op_write_ff <= req_write_i;
                op_lookup_ff <= dec_lookup;
                op_fill_ff <= ~req_write_i & dec_fill; // [RQ13] [RQ14] [RQ16] [RQ17]
                op_alloc_ff <= 1'b0;
                op_wb_ff <= 1'b0;
            end
            if (st_ff == ST_LOOK || st_ff == ST_DLOOK) begin
                vict_addr_ff <= {ent_tag, op_addr_ff[IDX_LSB +: IDX_W], 2'h0};
                vict_data_ff <= ent_data;
            end
        end
    end

    // write buffer: merge, insert, and release on drain
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_slot
            wire ins = buf_take && (ins_sel == gi);
            wire rel = idle && drain_go && (drain_sel == gi);
            always_ff @(posedge ref_clk_i) begin
                if (!resetn_i) begin
                    slot_vld_ff[gi] <= 1'b0;
                    slot_addr_ff[gi] <= 32'h0000_0000;
                    slot_data_ff[gi] <= 32'h0000_0000;
                    slot_use_ff[gi] <= '0;
                    {slot_lookup_ff[gi], slot_alloc_ff[gi], slot_wb_ff[gi]} <= 3'h0;
                end else if (rel) begin
                    slot_vld_ff[gi] <= 1'b0;
                end else if (ins) begin
                    // a merge counts as one more use of the slot
                    slot_vld_ff[gi] <= 1'b1;
                    slot_addr_ff[gi] <= req_addr_i;
                    slot_data_ff[gi] <= req_wdata_i;
                    slot_use_ff[gi] <= !merge ? '0 : (slot_use_ff[gi] == USE_MAX) ? USE_MAX : slot_use_ff[gi] + 1'b1;
                    slot_lookup_ff[gi] <= dec_lookup;
                    slot_alloc_ff[gi] <= dec_alloc;
                    slot_wb_ff[gi] <= dec_wb;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* testbench/l2_policy_chk.sv */
// port checker for the level-two policy block
// assumes it is bound to the top module; one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module l2_policy_chk
    import l2_policy_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [2:0] slave_port_protection_attrs_i,
    input wire logic shared_attribute_sideband_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic mem_valid_o,
    input wire logic mem_write_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [63:0] mem_wdata_o,
    input wire logic mem_ready_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic sh_ovr_ff;
    // decoded request kinds; the onc code is cacheable yet never buffered
    wire logic [2:0] at = slave_port_protection_attrs_i;
    wire logic take = req_valid_i && req_ready_o;
    wire logic unbuf = !at[1] || at == 3'h2;
    // shadow of the shared override, so shared reads are judged only when it is off
    always_ff @(posedge ref_clk_i)
        if (!resetn_i) sh_ovr_ff <= 1'b0;
        else if (reg_wr_i && reg_addr_i == CTRL_OFS) sh_ovr_ff <= reg_wdata_i[CTRL_SH_OVR_BIT];
    sequence mem_rd_s;
        mem_valid_o && !mem_write_o;
    endsequence
    sequence mem_wr_s;
        mem_valid_o && mem_write_o;
    endsequence
    upper_lanes_a: assert property (mem_valid_o |-> mem_wdata_o[63:32] == 32'h0)
        else $error("upper write lanes not zero");
    held_request_a: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o)
        && $stable(mem_wdata_o) && $stable(mem_write_o)) else $error("master request changed while waiting");
    unbuf_write_a: assert property (take && req_write_i && unbuf |-> ##[0:20] mem_wr_s)
        else $error("unbuffered write not sent to memory");
    uncached_read_a: assert property (take && !req_write_i && unbuf |-> ##[0:20] mem_rd_s)
        else $error("uncached read not sent to memory");
    shared_read_a: assert property (take && !req_write_i && at[1] && shared_attribute_sideband_i
        && !sh_ovr_ff |-> ##[0:20] mem_rd_s) else $error("shared read served without memory");
    read_answer_a: assert property (take && !req_write_i |-> ##[1:60] rsp_valid_o)
        else $error("read never answered");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    write_silent_a: assert property (take && req_write_i |=> !rsp_valid_o [*3])
        else $error("write produced a response");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("register data outside read slot");
    reset_quiet_a: assert property ($rose(resetn_i) |-> !mem_valid_o && !rsp_valid_o)
        else $error("outputs busy right after reset");
endmodule
bind l2_cache_attribute_policy l2_policy_chk chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .slave_port_protection_attrs_i(slave_port_protection_attrs_i), .req_ready_o(req_ready_o),
    .shared_attribute_sideband_i(shared_attribute_sideband_i), .rsp_valid_o(rsp_valid_o),
    .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ready_i(mem_ready_i));
`default_nettype wire

/* testbench/mem_model.sv */
// memory partner on the master port: word store, prompt or slow answers
// assumes one request at a time, each held until ready
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire logic write_i,
    input wire logic [31:0] addr_i,
    input wire logic [63:0] wdata_i,
    output logic ready_o,
    output logic rvalid_o,
    output logic [63:0] rdata_o
);
    logic [31:0] store [logic [31:0]];
    int wait_cnt;
    initial begin
        ready_o = 1'b0;
        rvalid_o = 1'b0;
        rdata_o = 64'h0;
    end
    // read lines toggle when idle so stale data never passes for an answer
    always @(posedge ref_clk_i) begin
        rvalid_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (!resetn_i) begin
            ready_o <= 1'b0;
            wait_cnt = 0;
        end else if (valid_i && ready_o) begin
            ready_o <= 1'b0;
            wait_cnt = 0;
            if (write_i) store[addr_i] = wdata_i[31:0];
            else begin
                rvalid_o <= 1'b1;
                rdata_o <= {2{store.exists(addr_i) ? store[addr_i] : 32'h0}};
            end
        end else if (valid_i) begin
            wait_cnt++;
            ready_o <= wait_cnt > (slow_i ? 3 : 0);
        end
    end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench: core requests, register port, memory partner
// assumes the design answers every request within a few dozen cycles
`timescale 1ns/1ns
`default_nettype none
module tb
    import l2_policy_pkg::*;
;
    logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, req_valid_i, req_write_i, shared_attribute_sideband_i, slow;
    logic req_ready_o, rsp_valid_o, mem_valid_o, mem_write_o, mem_ready_i, mem_rvalid_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, req_addr_i, req_wdata_i, reg_rdata_o, rsp_rdata_o, mem_addr_o, got;
    logic [2:0] slave_port_protection_attrs_i;
    logic [63:0] mem_wdata_o, mem_rdata_i;
    logic [31:0] ref_m [logic [31:0]];
    int errors, checked, nrd, nwr, exp_rd, exp_wr;
    int seed = 32'h1C15276D;
    l2_cache_attribute_policy uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .slave_port_protection_attrs_i(slave_port_protection_attrs_i), .req_ready_o(req_ready_o),
        .shared_attribute_sideband_i(shared_attribute_sideband_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_ready_i(mem_ready_i), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i));
    mem_model mem (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .slow_i(slow), .valid_i(mem_valid_o),
        .write_i(mem_write_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ready_o(mem_ready_i),
        .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // count master port transfers; the model predicts these counts
    always @(posedge ref_clk_i) begin
        if (mem_valid_o && mem_ready_i) begin
            if (mem_write_o) nwr++;
            else nrd++;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic reg_rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        got = reg_rdata_o;
    endtask
    // poll busy; a single early idle reading is not trusted
    task automatic settle;
        for (int i = 0; i < 100; i++) begin
            reg_rd(STAT_OFS);
            if (got[2] === 1'b0 && i > 0) break;
        end
    endtask
    // one word access, then traffic counts against the model; -1 resyncs a count
    task automatic op(input logic w, input logic [31:0] a, input logic [2:0] at, input logic sh,
        input int erd, input int ewr);
        logic [31:0] d;
        d = $random(seed);
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        slave_port_protection_attrs_i <= at;
        shared_attribute_sideband_i <= sh; // single words, never bursts
        for (int k = 0; k < 200; k++) begin
            @(posedge ref_clk_i);
            if (req_ready_o === 1'b1) break;
        end
        req_valid_i <= 1'b0;
        if (w) ref_m[a] = d;
        else begin
            for (int k = 0; k < 200; k++) begin
                @(posedge ref_clk_i);
                if (rsp_valid_o === 1'b1) break;
            end
            check(rsp_valid_o, 1'b1);
            check(rsp_rdata_o, ref_m.exists(a) ? ref_m[a] : 32'h0);
        end
        settle;
        exp_rd = erd < 0 ? nrd : exp_rd + erd;
        exp_wr = ewr < 0 ? nwr : exp_wr + ewr;
        check(nrd, exp_rd);
        check(nwr, exp_wr);
    endtask
    task end_of_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        end_of_test;
    end
    initial begin
        {errors, checked, nrd, nwr, exp_rd, exp_wr} = '0;
        {resetn_i, reg_wr_i, reg_rd_i, req_valid_i, req_write_i, shared_attribute_sideband_i, slow} = '0;
        {reg_addr_i, reg_wdata_i, req_addr_i, req_wdata_i, slave_port_protection_attrs_i} = '0;
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd(CTRL_OFS); check(got, 32'h0);
        reg_rd(8'h10); check(got, 32'h0);
        reg_wr(CTRL_OFS, 32'h3); reg_rd(CTRL_OFS); check(got, 32'h3);
        reg_wr(CTRL_OFS, 32'h0); reg_wr(8'h10, 32'hF); reg_rd(CTRL_OFS); check(got, 32'h0);
        op(1, 32'h100, 3'h0, 0, 0, 1); op(0, 32'h100, 3'h0, 0, 1, 0);
        op(1, 32'h104, 3'h1, 0, 0, 1); op(0, 32'h104, 3'h1, 1, 1, 0);
        op(1, 32'h104, 3'h2, 1, 0, 1); op(0, 32'h104, 3'h2, 0, 1, 0); op(0, 32'h104, 3'h2, 0, 1, 0);
        op(0, 32'h100, 3'h6, 0, 1, 0); op(0, 32'h104, 3'h6, 0, 1, 0);
        mem.store[32'h100] = ~ref_m[32'h100];
        op(0, 32'h100, 3'h6, 0, 0, 0);
        op(1, 32'h100, 3'h6, 0, 0, 0); reg_rd(STAT_OFS); check(got[1] ^ got[0], 1'b1);
        op(1, 32'h104, 3'h6, 0, 0, 2); check(mem.store[32'h100], ref_m[32'h100]);
        op(0, 32'h100, 3'h6, 0, 0, 0);
        slow = 1'b1;
        op(1, 32'h100, 3'h7, 0, 0, 0); op(1, 32'h104, 3'h7, 0, 0, 0); op(0, 32'h100, 3'h7, 0, 0, 0);
        op(0, 32'h140, 3'h7, 0, 1, 1); check(mem.store[32'h100], ref_m[32'h100]);
        op(1, 32'h184, 3'h7, 0, 0, 0); op(1, 32'h188, 3'h7, 0, 0, 2); op(0, 32'h184, 3'h7, 0, 1, 1);
        op(1, 32'h1C0, 3'h7, 0, 0, 0); op(0, 32'h1C0, 3'h7, 0, 1, 1);
        reg_wr(CTRL_OFS, 32'h1);
        op(1, 32'h208, 3'h7, 0, -1, -1); op(1, 32'h20C, 3'h7, 0, -1, -1); op(0, 32'h208, 3'h7, 0, 0, 0);
        reg_wr(CTRL_OFS, 32'h0);
        op(1, 32'h210, 3'h3, 0, -1, -1); op(1, 32'h214, 3'h3, 0, -1, -1); op(0, 32'h210, 3'h3, 0, 0, 0);
        op(0, 32'h218, 3'h3, 0, 1, 0);
        op(0, 32'h21C, 3'h6, 1, 1, 0); op(0, 32'h21C, 3'h6, 1, 1, 0);
        op(1, 32'h220, 3'h7, 1, 0, 0); op(1, 32'h224, 3'h7, 1, 0, 2);
        reg_wr(CTRL_OFS, 32'h2);
        op(0, 32'h21C, 3'h6, 1, 1, 0); op(0, 32'h21C, 3'h6, 1, 0, 0);
        end_of_test;
    end
endmodule
`default_nettype wire
